// ===== design/psc_pkg.sv
// Shared constants, types and helpers for the position subframe codec
`default_nettype none

package psc_pkg;

   // Clock and bit rates
   localparam int CLK_HZ = 25000000;
   localparam int BIT_RATE_SLOW_BPS = 6144000;
   localparam int BIT_RATE_FAST_BPS = 12288000;
   // Half of one line clock period in system cycles; line clock is twice the bit rate
   localparam int HC_SLOW_INT = CLK_HZ / (4 * BIT_RATE_SLOW_BPS);
   localparam int HC_FAST_INT = CLK_HZ / (4 * BIT_RATE_FAST_BPS);
   localparam logic [3:0] HC_SLOW_CYC = (HC_SLOW_INT < 1) ? 4'h1 : 4'(HC_SLOW_INT);
   localparam logic [3:0] HC_FAST_CYC = (HC_FAST_INT < 1) ? 4'h1 : 4'(HC_FAST_INT);

   // Sub frame layout
   localparam logic [4:0] PRE_LAST_BIT = 5'h03;
   localparam logic [4:0] POS_MSB_BIT = 5'h04;
   localparam int POS_FIRST = 4;
   localparam int POS_WIDTH = 20;
   localparam int EXT_FIRST = 24;
   localparam int ACK_BIT = 27;
   localparam int VALID_BIT = 28;
   localparam int SUBCODE_BIT = 29;
   localparam int CHSTAT_BIT = 30;
   localparam int PARITY_BIT = 31;
   localparam logic [4:0] LAST_BIT = 5'h1F;
   localparam logic [3:0] EXT_TO_HEAD = 4'h8;

   // Frame and block structure
   localparam logic [1:0] LAST_CH = 2'h3;
   localparam logic [7:0] LAST_FRAME = 8'hBF;
   localparam logic [2:0] PRE_HALVES_LAST = 3'h7;

   // Preamble half-cell levels, after a previous cell ending low / high
   localparam logic [7:0] PRE_B0 = 8'hE8;
   localparam logic [7:0] PRE_B1 = 8'h17;
   localparam logic [7:0] PRE_M0 = 8'hE2;
   localparam logic [7:0] PRE_M1 = 8'h1D;
   localparam logic [7:0] PRE_W0 = 8'hE4;
   localparam logic [7:0] PRE_W1 = 8'h1B;

   typedef enum logic [1:0] {
      PSC_PK_NONE = 2'h0,
      PSC_PK_BLOCK = 2'h1,
      PSC_PK_XCH = 2'h3,
      PSC_PK_OTHER = 2'h2
   } psc_pre_t;

   typedef enum logic [1:0] {
      PSC_HUNT = 2'h0,
      PSC_PRE = 2'h1,
      PSC_DATA = 2'h3
   } psc_rx_mode_t;

   typedef struct packed {
      logic [POS_WIDTH-1:0] pos;
      logic ack;
      logic invalid;
   } psc_tx_chan_t;

   typedef psc_tx_chan_t [3:0] psc_tx_frame_t;

   typedef struct packed {
      logic [1:0] ch;
      logic blk_start;
      logic [POS_WIDTH-1:0] pos;
      logic [3:0] ext;
   } psc_rx_word_t;

   // Classify nine half-cells: previous level then eight preamble halves
   function automatic psc_pre_t psc_match(input logic [8:0] h);
      psc_pre_t k;
      k = PSC_PK_NONE;
      if (h == {1'b0, PRE_B0} || h == {1'b1, PRE_B1})
      begin
         k = PSC_PK_BLOCK;
      end
      else if (h == {1'b0, PRE_M0} || h == {1'b1, PRE_M1})
      begin
         k = PSC_PK_XCH;
      end
      else if (h == {1'b0, PRE_W0} || h == {1'b1, PRE_W1})
      begin
         k = PSC_PK_OTHER;
      end
      return k;
   endfunction : psc_match

   function automatic logic [7:0] psc_pattern(input psc_pre_t k, input logic prev);
      logic [7:0] p;
      unique case (k)
         PSC_PK_BLOCK: p = prev ? PRE_B1 : PRE_B0;
         PSC_PK_XCH: p = prev ? PRE_M1 : PRE_M0;
         default: p = prev ? PRE_W1 : PRE_W0;
      endcase
      return p;
   endfunction : psc_pattern

endpackage : psc_pkg

`default_nettype wire

// ===== design/psc_bmc_rx.sv
// Inbound biphase mark deframer running on the controller's line clock
`default_nettype none

module psc_mark_rx
   import psc_pkg::*;
(
   input wire logic link_clk_i,
   input wire logic rst_i,
   input wire logic data_i,
   output logic locked_o,
   output psc_rx_word_t word_o,
   output logic word_tgl_o,
   output logic err_tgl_o
);

   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic din;
      logic [8:0] hist;
      psc_rx_mode_t mode;
      logic half;
      logic h0;
      logic [4:0] bitn;
      logic [31:0] sh;
      logic [1:0] ch;
      logic [7:0] frm;
      logic [2:0] cnt;
      logic blk;
      psc_rx_word_t word;
      logic word_tgl;
      logic err_tgl;
   } psc_rx_state_t;

   localparam psc_rx_state_t RX_RST = '0;

   psc_rx_state_t q;
   psc_rx_state_t d;
   logic [8:0] hn;
   psc_pre_t pk;
   psc_pre_t exp_pk;
   logic [1:0] nch;
   logic [7:0] nfrm;
   logic bitv;

   always_comb
   begin
      d = q;
      hn = {q.hist[7:0], q.din};
      pk = psc_match(hn);
      nch = q.ch + 2'h1;
      nfrm = (q.ch != LAST_CH) ? q.frm : ((q.frm == LAST_FRAME) ? 8'h00 : q.frm + 8'h01);
      // [RULE_18] block start expected
      exp_pk = (nch != 2'h0) ? PSC_PK_OTHER : ((nfrm == 8'h00) ? PSC_PK_BLOCK : PSC_PK_XCH);
      bitv = q.din ^ q.h0;
      d.din = data_i;
      d.hist = hn;
      d.rst_m = rst_i;
      d.rst_s = q.rst_m;
      unique case (q.mode)
         PSC_HUNT:
         begin
            // [RULE_05] sync on preamble
            if (pk == PSC_PK_BLOCK)
            begin
               d.mode = PSC_DATA;
               d.bitn = POS_MSB_BIT;
               d.half = 1'b0;
               d.ch = 2'h0;
               d.frm = 8'h00;
               d.blk = 1'b1;
            end
         end
         PSC_PRE:
         begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == PRE_HALVES_LAST)
            begin
               // [RULE_20] missing preamble resyncs
               if (pk == exp_pk)
               begin
                  d.mode = PSC_DATA;
                  d.bitn = POS_MSB_BIT;
                  d.half = 1'b0;
                  d.ch = nch;
                  d.frm = nfrm;
                  d.blk = (exp_pk == PSC_PK_BLOCK);
               end
               else
               begin
                  d.mode = PSC_HUNT;
                  d.err_tgl = ~q.err_tgl;
               end
            end
         end
         PSC_DATA:
         begin
            if (!q.half)
            begin
               d.h0 = q.din;
               d.half = 1'b1;
               // [RULE_04] boundary must invert
               if (q.din == q.hist[0])
               begin
                  d.mode = PSC_HUNT;
                  d.err_tgl = ~q.err_tgl;
               end
            end
            else
            begin
               d.half = 1'b0;
               // [RULE_03] two transitions mean one
               d.sh[q.bitn] = bitv;
               d.bitn = q.bitn + 5'h01;
               if (q.bitn == LAST_BIT)
               begin
                  d.mode = PSC_PRE;
                  d.cnt = 3'h0;
                  // [RULE_19] even parity checked
                  if (^{bitv, q.sh[PARITY_BIT-1:POS_FIRST]})
                  begin
                     d.mode = PSC_HUNT;
                     d.err_tgl = ~q.err_tgl;
                  end
                  // [RULE_14] invalid frames dropped
                  else if (!q.sh[VALID_BIT])
                  begin
                     d.word.ch = q.ch;
                     d.word.blk_start = q.blk;
                     d.word.ext = q.sh[ACK_BIT:EXT_FIRST];
                     // [RULE_10] first position bit is MSB
                     for (int i = 0; i < POS_WIDTH; i++)
                     begin
                        d.word.pos[POS_WIDTH-1-i] = q.sh[POS_FIRST+i];
                     end
                     d.word_tgl = ~q.word_tgl;
                  end
               end
            end
         end
         default:
         begin
            d.mode = PSC_HUNT;
         end
      endcase
      // Reset is synchronised into this domain; the line clock must run during it
      if (q.rst_s)
      begin
         d = RX_RST;
         d.rst_m = rst_i;
         d.rst_s = q.rst_m;
         d.din = data_i;
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      q <= d;
   end

   assign locked_o = (q.mode != PSC_HUNT);
   assign word_o = q.word;
   assign word_tgl_o = q.word_tgl;
   assign err_tgl_o = q.err_tgl;

endmodule : psc_mark_rx

`default_nettype wire

// ===== design/psc_codec.sv
// Scan-head end of the position serial link: outbound framer and inbound crossing
//
// Function
// [RULE_01] Default 6.144 Mb/s, optional 12.288 Mb/s; at CLK_HZ both settings give a half-cell of 2 clk_i cycles
// [RULE_02] Line clock runs at twice bit rate
// [RULE_03] One gives two transitions, zero one
// [RULE_04] Invert at cell start, mid-cell for one
// [RULE_05] 32-bit subframe opens with 4-bit preamble
// [RULE_06] Block-start preamble marks X and block
// [RULE_07] X preamble marks X, not block start
// [RULE_08] Other preamble marks every non-X channel
// [RULE_09] Preamble form follows previous parity cell
// [RULE_10] Bits 4-23 position, MSB first
// [RULE_11] Controller sends nominal position, extension 0001
// [RULE_12] Head returns actual position, maybe 16 bits
// [RULE_13] Last extension bit carries position acknowledge
// [RULE_14] Validity set means contents ignored
// [RULE_15] Sub-code and channel-status bits sent zero
// [RULE_16] Parity bit excludes the preamble
// [RULE_17] Frame is four subframes, one per channel
// [RULE_18] Block is 192 frames, starts with block preamble
// [RULE_19] Even parity over bits 4 to 31
// [RULE_20] Missing preamble or violation flags, resyncs
`default_nettype none

module psc_codec
   import psc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic head_inbound_clock_i,
   input wire logic head_inbound_data_i,
   input wire logic rate_fast_i,
   input wire logic trunc16_i,
   input wire psc_tx_frame_t tx_chan_i,
   output logic head_outbound_clock_o,
   output logic head_outbound_data_o,
   output logic tx_load_o,
   output psc_rx_word_t nominal_o,
   output logic nominal_stb_o,
   output logic framing_err_o,
   output logic [7:0] err_count_o,
   output logic link_locked_o
);

   typedef struct packed {
      logic [3:0] div;
      logic oclk;
      logic odata;
      logic half;
      logic [4:0] bitn;
      logic [1:0] ch;
      logic [7:0] frm;
      logic [7:0] pat;
      logic [31:0] sh;
      psc_tx_frame_t snap;
      logic load;
      logic wt_m;
      logic wt_s;
      logic wt_p;
      logic et_m;
      logic et_s;
      logic et_p;
      logic lk_m;
      logic lk_s;
      psc_rx_word_t nom;
      logic nom_stb;
      logic err;
      logic [7:0] errs;
   } psc_top_state_t;

   localparam psc_top_state_t TOP_RST = '0;

   psc_top_state_t q;
   psc_top_state_t d;

   logic rx_locked;
   psc_rx_word_t rx_word;
   logic rx_word_tgl;
   logic rx_err_tgl;

   logic [3:0] hc;
   logic [3:0] div_last;
   logic tick;
   psc_pre_t kind;
   logic [7:0] pat;
   psc_tx_chan_t src;
   logic [2:0] pidx;
   logic [7:0] nfrm;

   // Assemble one outbound sub frame, index equals bit position on the line
   function automatic logic [31:0] psc_build(input psc_tx_chan_t c, input logic trunc);
      logic [31:0] w;
      logic [POS_WIDTH-1:0] p;
      w = '0;
      p = c.pos;
      // [RULE_12] optional 16 valid bits
      if (trunc)
      begin
         p[3:0] = 4'h0;
      end
      // [RULE_10] MSB at bit 4
      for (int i = 0; i < POS_WIDTH; i++)
      begin
         w[POS_FIRST+i] = p[POS_WIDTH-1-i];
      end
      // [RULE_13] acknowledge in last extension bit
      w[ACK_BIT] = c.ack;
      w[VALID_BIT] = c.invalid;
      // [RULE_15] reserved bits zero
      w[SUBCODE_BIT] = 1'b0;
      w[CHSTAT_BIT] = 1'b0;
      // [RULE_16] parity skips preamble
      w[PARITY_BIT] = ^w[PARITY_BIT-1:POS_FIRST];
      return w;
   endfunction : psc_build

   psc_mark_rx u_rx (
      .link_clk_i(head_inbound_clock_i),
      .rst_i(rst_i),
      .data_i(head_inbound_data_i),
      .locked_o(rx_locked),
      .word_o(rx_word),
      .word_tgl_o(rx_word_tgl),
      .err_tgl_o(rx_err_tgl)
   );

   always_comb
   begin
      d = q;
      d.load = 1'b0;
      d.nom_stb = 1'b0;
      d.err = 1'b0;

      // [RULE_01] rate select
      hc = rate_fast_i ? HC_FAST_CYC : HC_SLOW_CYC;
      div_last = {hc[2:0], 1'b0} - 4'h1;
      tick = (q.div >= div_last);
      // [RULE_17] channel order within a frame
      // [RULE_18] block of 192 frames
      nfrm = (q.frm == LAST_FRAME) ? 8'h00 : q.frm + 8'h01;
      // [RULE_06] block start on X channel
      // [RULE_07] X channel elsewhere
      // [RULE_08] other channels
      kind = (q.ch != 2'h0) ? PSC_PK_OTHER : ((q.frm == 8'h00) ? PSC_PK_BLOCK : PSC_PK_XCH);
      // [RULE_09] form chosen by parity level
      pat = psc_pattern(kind, q.odata);
      src = (q.ch == 2'h0) ? tx_chan_i[0] : q.snap[q.ch];
      pidx = 3'h7 - {q.bitn[1:0], q.half};

      // [RULE_02] line clock of two half-cells per bit
      if (tick)
      begin
         d.div = 4'h0;
         d.oclk = 1'b1;
         if (q.bitn == 5'h00 && !q.half)
         begin
            d.pat = pat;
            d.odata = pat[7];
            d.sh = psc_build(src, trunc16_i);
            // Whole frame is taken at once so channels stay coherent
            if (q.ch == 2'h0)
            begin
               d.snap = tx_chan_i;
               d.load = 1'b1;
            end
         end
         else if (q.bitn <= PRE_LAST_BIT)
         begin
            // [RULE_05] preamble half-cells
            d.odata = q.pat[pidx];
         end
         else if (!q.half)
         begin
            // [RULE_04] invert at cell start
            d.odata = ~q.odata;
         end
         else
         begin
            // [RULE_03] mid-cell invert for one
            d.odata = q.odata ^ q.sh[q.bitn];
         end

         if (q.half)
         begin
            d.half = 1'b0;
            if (q.bitn == LAST_BIT)
            begin
               d.bitn = 5'h00;
               d.ch = q.ch + 2'h1;
               if (q.ch == LAST_CH)
               begin
                  d.frm = nfrm;
               end
            end
            else
            begin
               d.bitn = q.bitn + 5'h01;
            end
         end
         else
         begin
            d.half = 1'b1;
         end
      end
      else
      begin
         d.div = q.div + 4'h1;
         if (q.div == hc - 4'h1)
         begin
            d.oclk = 1'b0;
         end
      end

      // Inbound words cross by toggle; the word is held for a whole sub frame
      d.wt_m = rx_word_tgl;
      d.wt_s = q.wt_m;
      d.wt_p = q.wt_s;
      d.et_m = rx_err_tgl;
      d.et_s = q.et_m;
      d.et_p = q.et_s;
      d.lk_m = rx_locked;
      d.lk_s = q.lk_m;
      if (q.wt_s != q.wt_p)
      begin
         d.nom = rx_word;
         d.nom_stb = 1'b1;
      end
      // [RULE_20] framing error reported
      if (q.et_s != q.et_p)
      begin
         d.err = 1'b1;
         if (q.errs != 8'hFF)
         begin
            d.errs = q.errs + 8'h01;
         end
      end

      if (rst_i)
      begin
         d = TOP_RST;
      end
   end

   always_ff @(posedge clk_i)
   begin
      q <= d;
   end

   assign head_outbound_clock_o = q.oclk;
   assign head_outbound_data_o = q.odata;
   assign tx_load_o = q.load;
   assign nominal_o = q.nom;
   assign nominal_stb_o = q.nom_stb;
   assign framing_err_o = q.err;
   assign err_count_o = q.errs;
   assign link_locked_o = q.lk_s;

endmodule : psc_codec

`default_nettype wire

// ===== sim/psc_ctrl_model.sv
// Controller-side model streaming position sub frames into the head
`default_nettype none
module psc_ctrl_model
   import psc_pkg::*;
(
   input wire logic run_i,
   input wire logic [19:0] pos_i,
   input wire logic inv_i,
   input wire logic bad_i,
   input wire logic restart_i,
   output logic lclk_o,
   output logic dat_o,
   output logic done_o,
   output logic ok_o,
   output psc_rx_word_t rec_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [27:0] b;
   logic [7:0] pr;
   logic [1:0] ch;
   logic k;
   psc_rx_word_t r;
   int frm;
   initial
   begin
      lclk_o = 1'b0;
      #7;
      forever #62.5 lclk_o = ~lclk_o;
   end
   task automatic half(input logic v);
      @(negedge lclk_o);
      dat_o = v;
   endtask : half
   initial
   begin
      dat_o = 1'b0;
      done_o = 1'b0;
      ok_o = 1'b0;
      rec_o = '0;
      ch = 2'h0;
      frm = 0;
      wait (run_i);
      forever
      begin
         // Early block start lets the head resync without a full block wait
         if (restart_i)
         begin
            ch = 2'h0;
            frm = 0;
         end
         b = {pos_i, 4'h1, inv_i, 2'h0, bad_i ^ (^{pos_i, 1'b1, inv_i})};
         k = !inv_i && !bad_i;
         r = {ch, ch == 2'h0 && frm == 0, pos_i, EXT_TO_HEAD};
         pr = (ch != 2'h0) ? PRE_W0 : (frm == 0) ? PRE_B0 : PRE_M0;
         if (dat_o)
            pr = ~pr;
         for (int i = 7; i >= 0; i--)
            half(pr[i]);
         for (int i = 27; i >= 0; i--)
         begin
            half(~dat_o);
            half(dat_o ^ b[i]);
         end
         @(posedge lclk_o);
         rec_o = r;
         ok_o = k;
         done_o = ~done_o;
         ch = ch + 2'h1;
         if (ch == 2'h0)
            frm = (frm + 1) % 192;
      end
   end
endmodule : psc_ctrl_model
`default_nettype wire

// ===== sim/psc_checker.sv
// Port-level assertions for the position subframe codec
`default_nettype none
module psc_checker
   import psc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic head_inbound_clock_i,
   input wire logic head_inbound_data_i,
   input wire logic rate_fast_i,
   input wire logic trunc16_i,
   input wire psc_tx_frame_t tx_chan_i,
   input wire logic head_outbound_clock_o,
   input wire logic head_outbound_data_o,
   input wire logic tx_load_o,
   input wire psc_rx_word_t nominal_o,
   input wire logic nominal_stb_o,
   input wire logic framing_err_o,
   input wire logic [7:0] err_count_o,
   input wire logic link_locked_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] hn_q;
   logic [5:0] cur;
   logic lv_q;
   logic [9:0] lc_q;
   logic sn_q;
   // Half-cell index within the sub frame now on the line
   assign cur = tx_load_o ? 6'h0 : hn_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hn_q <= 6'h0;
         lv_q <= 1'b0;
         lc_q <= 10'h0;
         sn_q <= 1'b0;
      end
      else
      begin
         lc_q <= tx_load_o ? 10'h1 : lc_q + 10'h1;
         sn_q <= sn_q | tx_load_o;
         if (head_outbound_clock_o)
         begin
            hn_q <= cur + 6'h1;
            lv_q <= head_outbound_data_o;
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   clock_shape_a:
   assert property ($rose(head_outbound_clock_o) |=> !head_outbound_clock_o ##1
      head_outbound_clock_o) else $error("outbound clock shape wrong");
   data_edge_a:
   assert property ($changed(head_outbound_data_o) |-> $rose(head_outbound_clock_o))
      else $error("outbound data moved off clock edge");
   cell_start_a:
   assert property (head_outbound_clock_o && (cur == 6'h0 || cur >= 6'h8) && !cur[0]
      |-> head_outbound_data_o != lv_q) else $error("no inversion at cell start");
   pre_hold_a:
   assert property (head_outbound_clock_o && cur == 6'h2 |-> head_outbound_data_o == lv_q)
      else $error("preamble lacks held boundary");
   load_edge_a:
   assert property (tx_load_o |-> $rose(head_outbound_clock_o))
      else $error("load not at half-cell start");
   load_gap_a:
   assert property (tx_load_o && sn_q |-> lc_q == 10'h200)
      else $error("frame is not four sub frames long");
   word_gap_a:
   assert property (nominal_stb_o |=> !nominal_stb_o [*8]) else $error("words too close");
   block_ch_a:
   assert property (nominal_stb_o && nominal_o.blk_start |-> nominal_o.ch == 2'h0)
      else $error("block start on non-X channel");
   err_step_a:
   assert property ($changed(err_count_o) |-> err_count_o == $past(err_count_o) + 8'h1)
      else $error("error count step wrong");
   err_unlock_a:
   assert property (framing_err_o |-> ##[0:8] !link_locked_o)
      else $error("no unlock after framing error");
   cover property (tx_load_o);
   cover property (nominal_stb_o && nominal_o.blk_start);
   cover property (framing_err_o);
endmodule : psc_checker
bind psc_codec psc_checker psc_chk (.clk_i, .rst_i, .head_inbound_clock_i,
   .head_inbound_data_i, .rate_fast_i, .trunc16_i, .tx_chan_i, .head_outbound_clock_o,
   .head_outbound_data_o, .tx_load_o, .nominal_o, .nominal_stb_o, .framing_err_o,
   .err_count_o, .link_locked_o);
`default_nettype wire

// ===== sim/psc_codec_test.sv
// Self-checking bench for the position subframe codec
`default_nettype none
module psc_codec_test
   import psc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, rate_fast_i, trunc16_i, head_inbound_clock_i, head_inbound_data_i;
   logic head_outbound_clock_o, head_outbound_data_o, tx_load_o, nominal_stb_o;
   logic framing_err_o, link_locked_o, run, inv, bad, restart, done, ok, tr, lv, oc_q, dn_q;
   logic [7:0] err_count_o;
   logic [19:0] pos, p;
   logic [27:0] b;
   logic [63:0] hv, e;
   logic [95:0] r;
   logic [1:0] ch;
   psc_tx_frame_t tx_chan_i, ex;
   psc_rx_word_t nominal_o, rec;
   psc_rx_word_t q[$];
   int error_cnt, check_count, frm, hi, nerr;
   psc_codec uut (.clk_i, .rst_i, .head_inbound_clock_i, .head_inbound_data_i, .rate_fast_i,
      .trunc16_i, .tx_chan_i, .head_outbound_clock_o, .head_outbound_data_o, .tx_load_o,
      .nominal_o, .nominal_stb_o, .framing_err_o, .err_count_o, .link_locked_o);
   psc_ctrl_model ctl (.run_i(run), .pos_i(pos), .inv_i(inv), .bad_i(bad),
      .restart_i(restart), .lclk_o(head_inbound_clock_i), .dat_o(head_inbound_data_i),
      .done_o(done), .ok_o(ok), .rec_o(rec));
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [63:0] x, input logic [63:0] s);
      check_count++;
      if (s !== x)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   // Counts sub frames finished by the controller, bounded
   task automatic wait_sf(input int n);
      logic d;
      for (int k = 0; k < 12000 && n > 0; k++)
      begin
         d = done;
         @(negedge clk_i);
         if (done !== d)
            n--;
      end
      if (n > 0)
      begin
         error_cnt++;
         $display("[ERR] sub frame wait expected done seen stuck");
         results();
      end
   endtask : wait_sf
   function automatic logic [63:0] enc(input logic [7:0] pre, input logic v,
      input logic [27:0] d);
      logic [63:0] h;
      h = {v ? ~pre : pre, 56'h0};
      v = v ^ pre[0];
      for (int i = 27; i >= 0; i--)
      begin
         v = ~v;
         h[2 * i + 1] = v;
         v = v ^ d[i];
         h[2 * i] = v;
      end
      return h;
   endfunction : enc
   always @(negedge clk_i)
   begin
      if (!rst_i && {oc_q, head_outbound_clock_o} === 2'b01)
      begin
         if (tx_load_o === 1'b1)
         begin
            ex = tx_chan_i;
            ch = 2'h0;
            hi = 0;
            frm = (frm + 1) % 192;
            r = {$urandom, $urandom, $urandom};
            tx_chan_i <= r[87:0];
            trunc16_i <= r[88];
         end
         hv = {hv[62:0], head_outbound_data_o};
         hi++;
         // Truncation is read live at every sub frame start, not held with the load
         if (hi == 1)
            tr = trunc16_i;
         if (frm >= 0 && hi == 64)
         begin
            p = tr ? {ex[ch].pos[19:4], 4'h0} : ex[ch].pos;
            b = {p, 3'h0, ex[ch].ack, ex[ch].invalid, 2'h0, ^{p, ex[ch].ack, ex[ch].invalid}};
            e = enc(ch != 2'h0 ? PRE_W0 : frm == 0 ? PRE_B0 : PRE_M0, lv, b);
            chk("tx preamble", e[63:56], hv[63:56]);
            chk("tx cells", e, hv);
            lv = e[0];
            ch++;
            hi = 0;
         end
      end
      oc_q = head_outbound_clock_o;
      if (done !== dn_q)
      begin
         if (ok === 1'b1)
            q.push_back(rec);
         r = {$urandom, $urandom, $urandom};
         pos <= r[19:0];
         inv <= r[22:20] == 3'h0;
      end
      dn_q = done;
      if (nominal_stb_o === 1'b1)
      begin
         if (q.size() == 0)
            chk("spare word", 0, 1);
         else
            chk("nominal word", q.pop_front(), nominal_o);
      end
      if (framing_err_o === 1'b1)
         nerr++;
   end
   initial
   begin
      void'($urandom(32'hC21ADD08));
      {rst_i, rate_fast_i, trunc16_i, run, inv, bad, restart} = 7'h40;
      {lv, oc_q, dn_q} = 3'h0;
      {error_cnt, check_count, nerr, hi} = 128'h0;
      frm = -1;
      tx_chan_i = {20'hFFFFF, 2'h3, 20'h00000, 2'h0, 20'h7FFFF, 2'h1, 20'h80000, 2'h2};
      pos = 20'h80000;
      // One inbound edge inside reset is enough; the link side needs two more to clear
      repeat (3) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (10) @(negedge clk_i);
      run = 1'b1;
      wait_sf(40);
      chk("locked", 1, link_locked_o);
      $display("test stream done");
      bad = 1'b1;
      wait_sf(1);
      bad = 1'b0;
      restart = 1'b1;
      wait_sf(1);
      restart = 1'b0;
      wait_sf(12);
      chk("error count", 1, err_count_o);
      chk("error pulses", 1, nerr);
      chk("relocked", 1, link_locked_o);
      $display("test resync done");
      rate_fast_i = 1'b1;
      wait_sf(12);
      $display("test fast rate done");
      results();
   end
endmodule : psc_codec_test
`default_nettype wire
